// *** dv/lpmc_far_model.sv ***
// Far side: processor requests, wake event lines and reset pins
`timescale 1ns/1ps
`default_nettype none
module lpmc_far_model (
	input  wire logic [31:0] r_i,
	input  wire logic        cpu_clk_en_i,
	output logic             sleep_req_o,
	output logic             periph_event_o,
	output logic             voltage_detector_output_o,
	output logic             eth_wake_o,
	output logic             reset_pin_n_o,
	output logic             independent_watchdog_rst_o,
	output logic [15:0]      ext_int_lines_o,
	output logic [3:0]       rtc_evt_o,
	output logic [1:0]       usb_wake_o
);
	// A halted processor cannot ask again
	assign sleep_req_o = cpu_clk_en_i && r_i[1:0] == 2'h0;
	assign periph_event_o = r_i[4:2] == 3'h0;
	assign ext_int_lines_o = r_i[7:5] == 3'h0 ? 16'h0001 << r_i[11:8] : 16'h0000;
	assign voltage_detector_output_o = r_i[14:12] == 3'h0;
	assign rtc_evt_o = r_i[17:15] == 3'h0 ? 4'h1 << r_i[19:18] : 4'h0;
	assign usb_wake_o = r_i[22:20] == 3'h0 ? 2'h1 << r_i[23] : 2'h0;
	assign eth_wake_o = r_i[26:24] == 3'h0;
	assign reset_pin_n_o = r_i[29:27] != 3'h0;
	assign independent_watchdog_rst_o = r_i[31:30] == 2'h0;
endmodule // lpmc_far_model
`default_nettype wire

// *** dv/lpmc_top_assertions.sv ***
// Port assertions for the low-power mode controller
`timescale 1ns/1ps
`default_nettype none
`include "lpmc_cfg.svh"
module lpmc_top_chk #(
	parameter int EXT_LINES = 16
) (
	input wire logic                       clk_i,
	input wire logic                       arst_n_i,
	input wire logic                       ce_i,
	input wire logic                       sleep_req_i,
	input wire logic                       deep_sel_i,
	input wire logic                       standby_sel_i,
	input wire logic                       low_power_regulator_sel_i,
	input wire logic                       underdrive_sel_i,
	input wire logic                       reg_bypass_i,
	input wire logic                       periph_event_i,
	input wire logic [EXT_LINES-1:0]       ext_int_lines_i,
	input wire logic                       reset_pin_n_i,
	input wire logic                       independent_watchdog_rst_i,
	input wire logic                       vbat_meas_en_i,
	input wire logic [`LPMC_RTC_EVTS-1:0]  rtc_evt_i,
	input wire logic [`LPMC_MODE_W-1:0]    mode_o,
	input wire logic                       cpu_clk_en_o,
	input wire logic                       periph_clk_en_o,
	input wire logic                       core_clk_en_o,
	input wire logic                       pll_en_o,
	input wire logic                       sys_rst_o,
	input wire logic                       main_regulator_en_o,
	input wire logic                       low_power_regulator_en_o,
	input wire logic                       regulator_underdrive_o,
	input wire logic                       core_pwr_en_o,
	input wire logic                       sram_retain_o,
	input wire logic                       standby_refused_o,
	input wire logic                       conv_temp_o,
	input wire logic                       conv_vbat_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	// Request taken only in run with the clock enabled
	wire rq = ce_i && sleep_req_i && mode_o == 3'h0;
	property p_sleep; mode_o == 3'h1 |-> !cpu_clk_en_o && periph_clk_en_o; endproperty
	a_sleep: assert property (p_sleep) else $error("sleep clocks");
	property p_swake; mode_o == 3'h1 && ce_i && periph_event_i |=> cpu_clk_en_o; endproperty
	a_swake: assert property (p_swake) else $error("sleep wake");
	property p_stop; mode_o == 3'h2 |-> !core_clk_en_o && !pll_en_o && sram_retain_o; endproperty
	a_stop: assert property (p_stop) else $error("stop clocks");
	property p_sreg; rq && deep_sel_i && !standby_sel_i |=> mode_o == 3'h2 && main_regulator_en_o
		!= low_power_regulator_en_o && low_power_regulator_en_o == $past(low_power_regulator_sel_i)
		&& regulator_underdrive_o == $past(underdrive_sel_i); endproperty
	a_sreg: assert property (p_sreg) else $error("stop regulator");
	property p_xwake; mode_o == 3'h2 && ce_i && |ext_int_lines_i |=> mode_o == 3'h0; endproperty
	a_xwake: assert property (p_xwake) else $error("stop wake");
	property p_stby; mode_o == 3'h3 |-> !core_pwr_en_o && !main_regulator_en_o
		&& !low_power_regulator_en_o && !pll_en_o && !sram_retain_o; endproperty
	a_stby: assert property (p_stby) else $error("standby power");
	property p_bwake; mode_o == 3'h3 && ce_i && (!reset_pin_n_i || independent_watchdog_rst_i
		|| |rtc_evt_i) |=> sys_rst_o && mode_o == 3'h4 && !cpu_clk_en_o; endproperty
	a_bwake: assert property (p_bwake) else $error("standby exit");
	property p_byp; rq && deep_sel_i && standby_sel_i && reg_bypass_i
		|=> mode_o == 3'h0 && standby_refused_o; endproperty
	a_byp: assert property (p_byp) else $error("bypass refusal");
	property p_conv; $past(ce_i) && $past(vbat_meas_en_i) |-> conv_vbat_o && !conv_temp_o; endproperty
	a_conv: assert property (p_conv) else $error("shared channel");
endmodule // lpmc_top_chk
bind lpmc_top lpmc_top_chk #(.EXT_LINES(EXT_LINES)) lpmc_top_chk_i (.*);
`default_nettype wire

// *** dv/lpmc_top_tb.sv ***
// Self-checking bench for the low-power mode controller
`timescale 1ns/1ps
`default_nettype none
module lpmc_top_tb;
	localparam int RC = 4;
	logic clk_i, arst_n_i, sreq, pev, vdo, eth, rpn, wdg;
	logic [31:0] r1, r2;
	logic [15:0] ext;
	logic [3:0] rtc;
	logic [2:0] mode;
	logic [1:0] usb;
	logic cpu, per, cor, pll, rco, xto, mre, lpe, udo, cpw, srr, bkr, srs, rfo, flo, ctp, cvb;
	int m, fl, el, eu, eb, rf, cv, ct, rc, wp, n, lce, fails, n_checks;
	lpmc_far_model lpmc_far_model_i (.r_i(r1), .cpu_clk_en_i(cpu), .sleep_req_o(sreq),
		.periph_event_o(pev), .voltage_detector_output_o(vdo), .eth_wake_o(eth),
		.reset_pin_n_o(rpn), .independent_watchdog_rst_o(wdg), .ext_int_lines_o(ext),
		.rtc_evt_o(rtc), .usb_wake_o(usb));
	lpmc_top #(.RST_CYC(RC)) lpmc_top_i (.clk_i(clk_i), .arst_n_i(arst_n_i),
		.ce_i(r2[2:0] != 3'h0), .sleep_req_i(sreq), .deep_sel_i(r2[3]), .standby_sel_i(r2[4]),
		.low_power_regulator_sel_i(r2[5]), .underdrive_sel_i(r2[6]), .reg_bypass_i(r2[7] & r2[8]),
		.bkp_sram_retain_sel_i(r2[9]), .periph_event_i(pev), .ext_int_lines_i(ext),
		.voltage_detector_output_i(vdo), .rtc_evt_i(rtc), .usb_wake_i(usb), .eth_wake_i(eth),
		.reset_pin_n_i(rpn), .independent_watchdog_rst_i(wdg), .wakeup_pin_i(r2[10]),
		.standby_flag_clr_i(r2[13:11] == 3'h0), .temp_sensor_en_i(r2[14]), .vbat_meas_en_i(r2[15]),
		.cpu_clk_en_o(cpu), .periph_clk_en_o(per), .core_clk_en_o(cor), .pll_en_o(pll),
		.internal_rc_osc_en_o(rco), .external_crystal_osc_en_o(xto), .main_regulator_en_o(mre),
		.low_power_regulator_en_o(lpe), .regulator_underdrive_o(udo), .core_pwr_en_o(cpw),
		.sram_retain_o(srr), .bkp_sram_retain_o(bkr), .sys_rst_o(srs), .standby_refused_o(rfo),
		.standby_flag_o(flo), .mode_o(mode), .conv_temp_o(ctp), .conv_vbat_o(cvb));
	// Reference model; holds still for two edges while the reset synchroniser drains
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			m = 0;
			fl = 0;
			rf = 0;
			cv = 0;
			ct = 0;
			rc = 0;
			lce = 0;
			wp = 1;
		end else if (rc < 2) rc++;
		else begin
			lce = r2[2:0] != 0;
			if (lce) begin
				rf = 0;
				if (r2[13:11] == 0) fl = 0;
				case (m)
					0: if (sreq) begin
						if (!r2[3]) m = 1;
						else if (!r2[4]) m = 2;
						else if (r2[7] & r2[8]) rf = 1;
						else begin
							m = 3;
							fl = 1;
						end
					end
					1: if (pev || ext != 0 || vdo || rtc != 0 || usb != 0 || eth) m = 0;
					2: if (ext != 0 || vdo || rtc != 0 || usb != 0 || eth) m = 0;
					3: if (!rpn || wdg || (r2[10] && !wp) || rtc != 0) begin
						m = 4;
						n = RC;
					end
					4: if (--n == 0) m = 0;
				endcase
				// Regulator and retention selects are levels, taken on every enabled edge
				el = r2[5];
				eu = r2[6];
				eb = r2[9];
				wp = r2[10];
				cv = r2[15];
				ct = r2[14] && !r2[15];
			end
		end
	end
	task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
		n_checks++;
		if (s !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic cmp();
		logic dp;
		dp = m == 2 || m == 3;
		chk("clocks", {mode, cpu, per, cor, pll, rco}, {m[2:0], m == 0, {4{!dp}}});
		chk("power", {xto, mre, lpe, udo, cpw, srr, bkr, srs}, {!dp, m == 2 ? !el[0] : m != 3,
			m == 2 && el[0], m == 2 && eu[0], m != 3, m != 3, m == 3 ? eb[0] : 1'b1, m == 4});
		if (lce) chk("flags", {4'h0, flo, rfo, ctp, cvb}, {4'h0, fl[0], rf[0], ct[0], cv[0]});
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Idle far side and no requests, so nothing lands inside the reset drain
	task automatic quiet(int k);
		r1 = '1;
		r2 = '0;
		repeat (k) @(posedge clk_i);
		#1;
	endtask
	initial begin
		clk_i = 0;
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		#(4100 * 20);
		fails++;
		stop_test();
	end
	initial begin
		arst_n_i = 1'b0;
		r1 = '1;
		r2 = '0;
		fails = 0;
		n_checks = 0;
		void'($urandom(50));
		quiet(5);
		arst_n_i = 1;
		quiet(3);
		for (int i = 0; i < 4000; i++) begin
			if (i == 2000) begin
				arst_n_i = 0;
				quiet(5);
				arst_n_i = 1;
				quiet(3);
			end
			r1 = $urandom;
			r2 = $urandom;
			@(posedge clk_i);
			#1 cmp();
		end
		stop_test();
	end
endmodule // lpmc_top_tb
`default_nettype wire

// *** hw/lpmc_cfg.svh ***
// Timing constants, widths and mode encodings of the low-power mode controller
`ifndef LPMC_CFG_SVH
`define LPMC_CFG_SVH
`define LPMC_CLK_PERIOD_NS 10
`define LPMC_RST_HOLD_NS   100
`define LPMC_RST_HOLD_CYC  ((`LPMC_RST_HOLD_NS + `LPMC_CLK_PERIOD_NS - 1) / `LPMC_CLK_PERIOD_NS)
`define LPMC_EXT_LINES     16
`define LPMC_RTC_EVTS      4
`define LPMC_USB_WKUPS     2
`define LPMC_MODE_W        3
`define LPMC_MODE_RUN      3'h0
`define LPMC_MODE_SLEEP    3'h1
`define LPMC_MODE_STOP     3'h2
`define LPMC_MODE_STANDBY  3'h3
`define LPMC_MODE_RESET    3'h4
`endif

// *** hw/lpmc_pkg.sv ***
// Types of the low-power mode controller
package lpmc_pkg;
	typedef enum logic [2:0] {
		LPMC_RUN,
		LPMC_SLEEP,
		LPMC_STOP,
		LPMC_STANDBY,
		LPMC_RESTART
	} lpmc_state_t;
endpackage

// *** hw/lpmc_top.sv ***
// Low-power mode controller: sleep, stop and standby sequencing
`timescale 1ns/1ps
`default_nettype none
`include "lpmc_cfg.svh"
module lpmc_top
	import lpmc_pkg::*;
#(
	parameter int EXT_LINES = `LPMC_EXT_LINES,
	parameter int RST_CYC   = `LPMC_RST_HOLD_CYC
) (
	input  wire logic                 clk_i,
	input  wire logic                 arst_n_i,
	input  wire logic                 ce_i,
	input  wire logic                 sleep_req_i,
	input  wire logic                 deep_sel_i,
	input  wire logic                 standby_sel_i,
	input  wire logic                 low_power_regulator_sel_i,
	input  wire logic                 underdrive_sel_i,
	input  wire logic                 reg_bypass_i,
	input  wire logic                 bkp_sram_retain_sel_i,
	input  wire logic                 periph_event_i,
	input  wire logic [EXT_LINES-1:0] ext_int_lines_i,
	input  wire logic                 voltage_detector_output_i,
	input  wire logic [`LPMC_RTC_EVTS-1:0] rtc_evt_i,
	input  wire logic [`LPMC_USB_WKUPS-1:0] usb_wake_i,
	input  wire logic                 eth_wake_i,
	input  wire logic                 reset_pin_n_i,
	input  wire logic                 independent_watchdog_rst_i,
	input  wire logic                 wakeup_pin_i,
	input  wire logic                 standby_flag_clr_i,
	input  wire logic                 temp_sensor_en_i,
	input  wire logic                 vbat_meas_en_i,
	output logic                      cpu_clk_en_o,
	output logic                      periph_clk_en_o,
	output logic                      core_clk_en_o,
	output logic                      pll_en_o,
	output logic                      internal_rc_osc_en_o,
	output logic                      external_crystal_osc_en_o,
	output logic                      main_regulator_en_o,
	output logic                      low_power_regulator_en_o,
	output logic                      regulator_underdrive_o,
	output logic                      core_pwr_en_o,
	output logic                      sram_retain_o,
	output logic                      bkp_sram_retain_o,
	output logic                      sys_rst_o,
	output logic                      standby_refused_o,
	output logic                      standby_flag_o,
	output logic [`LPMC_MODE_W-1:0]   mode_o,
	output logic                      conv_temp_o,
	output logic                      conv_vbat_o
);
	if (RST_CYC < 1) begin : g_chk
		$error("RST_CYC must be at least one cycle");
	end
	if (EXT_LINES < 1) begin : g_chk_lines
		$error("EXT_LINES must be at least one");
	end

	localparam int CNT_W = $clog2(RST_CYC + 1);

	logic             rst_s1_r;
	logic             rst_n_r;
	lpmc_state_t      state_r;
	lpmc_state_t      state_nxt;
	logic [CNT_W-1:0] rst_cnt_r;
	logic             stop_wake;
	logic             standby_wake;
	logic             refuse_nxt;

	// Reset is asserted at once but released only after two clean edges
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_s1_r <= 1'b0;
			rst_n_r  <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r  <= rst_s1_r;
		end
	end

	lpmc_wake_detect #(
		.EXT_LINES (EXT_LINES)
	) u_wake (
		.clk_i                      (clk_i),
		.rst_n_i                    (rst_n_r),
		.ce_i                       (ce_i),
		.ext_int_lines_i            (ext_int_lines_i),
		.voltage_detector_output_i  (voltage_detector_output_i),
		.rtc_evt_i                  (rtc_evt_i),
		.usb_wake_i                 (usb_wake_i),
		.eth_wake_i                 (eth_wake_i),
		.reset_pin_n_i              (reset_pin_n_i),
		.independent_watchdog_rst_i (independent_watchdog_rst_i),
		.wakeup_pin_i               (wakeup_pin_i),
		.stop_wake_o                (stop_wake),
		.standby_wake_o             (standby_wake)
	);

	always_comb begin
		state_nxt  = state_r;
		refuse_nxt = 1'b0;
		case (state_r)
			LPMC_RUN: begin
				if (sleep_req_i) begin
					if (!deep_sel_i) begin
						state_nxt = LPMC_SLEEP;
					end else if (!standby_sel_i) begin
						state_nxt = LPMC_STOP;
					end else if (reg_bypass_i) begin
						refuse_nxt = 1'b1;
					end else begin
						state_nxt = LPMC_STANDBY;
					end
				end
			end
			LPMC_SLEEP: begin
				if (periph_event_i || stop_wake) begin
					state_nxt = LPMC_RUN;
				end
			end
			LPMC_STOP: begin
				if (stop_wake) begin
					state_nxt = LPMC_RUN;
				end
			end
			LPMC_STANDBY: begin
				if (standby_wake) begin
					state_nxt = LPMC_RESTART;
				end
			end
			LPMC_RESTART: begin
				if (rst_cnt_r == CNT_W'(RST_CYC - 1)) begin
					state_nxt = LPMC_RUN;
				end
			end
			default: begin
				state_nxt = LPMC_RUN;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			state_r <= LPMC_RUN;
		end else if (ce_i) begin
			state_r <= state_nxt;
		end
	end

	// Core state is gone after standby, so a full reset pulse is replayed
	always_ff @(posedge clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			rst_cnt_r <= '0;
		end else if (ce_i) begin
			if (state_r == LPMC_RESTART) begin
				rst_cnt_r <= rst_cnt_r + CNT_W'(1);
			end else begin
				rst_cnt_r <= '0;
			end
		end
	end

	// Outputs follow the next state so they change with the state register
	always_ff @(posedge clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			cpu_clk_en_o              <= 1'b1;
			periph_clk_en_o           <= 1'b1;
			core_clk_en_o             <= 1'b1;
			pll_en_o                  <= 1'b1;
			internal_rc_osc_en_o      <= 1'b1;
			external_crystal_osc_en_o <= 1'b1;
			main_regulator_en_o       <= 1'b1;
			low_power_regulator_en_o  <= 1'b0;
			regulator_underdrive_o    <= 1'b0;
			core_pwr_en_o             <= 1'b1;
			sram_retain_o             <= 1'b1;
			bkp_sram_retain_o         <= 1'b1;
			sys_rst_o                 <= 1'b0;
			mode_o                    <= `LPMC_MODE_RUN;
		end else if (ce_i) begin
			cpu_clk_en_o              <= 1'b1;
			periph_clk_en_o           <= 1'b1;
			core_clk_en_o             <= 1'b1;
			pll_en_o                  <= 1'b1;
			internal_rc_osc_en_o      <= 1'b1;
			external_crystal_osc_en_o <= 1'b1;
			main_regulator_en_o       <= 1'b1;
			low_power_regulator_en_o  <= 1'b0;
			regulator_underdrive_o    <= 1'b0;
			core_pwr_en_o             <= 1'b1;
			sram_retain_o             <= 1'b1;
			bkp_sram_retain_o         <= 1'b1;
			sys_rst_o                 <= 1'b0;
			case (state_nxt)
				LPMC_RUN: begin
					mode_o <= `LPMC_MODE_RUN;
				end
				LPMC_SLEEP: begin
					cpu_clk_en_o <= 1'b0;
					mode_o       <= `LPMC_MODE_SLEEP;
				end
				LPMC_STOP: begin
					cpu_clk_en_o              <= 1'b0;
					periph_clk_en_o           <= 1'b0;
					core_clk_en_o             <= 1'b0;
					pll_en_o                  <= 1'b0;
					internal_rc_osc_en_o      <= 1'b0;
					external_crystal_osc_en_o <= 1'b0;
					main_regulator_en_o       <= !low_power_regulator_sel_i;
					low_power_regulator_en_o  <= low_power_regulator_sel_i;
					regulator_underdrive_o    <= underdrive_sel_i;
					sram_retain_o             <= 1'b1;
					mode_o                    <= `LPMC_MODE_STOP;
				end
				LPMC_STANDBY: begin
					cpu_clk_en_o              <= 1'b0;
					periph_clk_en_o           <= 1'b0;
					core_clk_en_o             <= 1'b0;
					pll_en_o                  <= 1'b0;
					internal_rc_osc_en_o      <= 1'b0;
					external_crystal_osc_en_o <= 1'b0;
					main_regulator_en_o       <= 1'b0;
					core_pwr_en_o             <= 1'b0;
					sram_retain_o             <= 1'b0;
					bkp_sram_retain_o         <= bkp_sram_retain_sel_i;
					mode_o                    <= `LPMC_MODE_STANDBY;
				end
				LPMC_RESTART: begin
					cpu_clk_en_o <= 1'b0;
					sys_rst_o    <= 1'b1;
					mode_o       <= `LPMC_MODE_RESET;
				end
				default: begin
					mode_o <= `LPMC_MODE_RUN;
				end
			endcase
		end
	end

	// Flag survives the restart; a new standby entry wins over a clear
	always_ff @(posedge clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			standby_flag_o    <= 1'b0;
			standby_refused_o <= 1'b0;
		end else if (ce_i) begin
			standby_refused_o <= refuse_nxt;
			if (state_r != LPMC_STANDBY && state_nxt == LPMC_STANDBY) begin
				standby_flag_o <= 1'b1;
			end else if (standby_flag_clr_i) begin
				standby_flag_o <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_r) begin
		if (!rst_n_r) begin
			conv_temp_o <= 1'b0;
			conv_vbat_o <= 1'b0;
		end else if (ce_i) begin
			conv_temp_o <= temp_sensor_en_i & !vbat_meas_en_i;
			conv_vbat_o <= vbat_meas_en_i;
		end
	end
endmodule // lpmc_top
`default_nettype wire

// *** hw/lpmc_wake_detect.sv ***
// Wake source gathering for stop and standby exit
`timescale 1ns/1ps
`default_nettype none
`include "lpmc_cfg.svh"
module lpmc_wake_detect #(
	parameter int EXT_LINES = `LPMC_EXT_LINES
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_n_i,
	input  wire logic                  ce_i,
	input  wire logic [EXT_LINES-1:0]  ext_int_lines_i,
	input  wire logic                  voltage_detector_output_i,
	input  wire logic [`LPMC_RTC_EVTS-1:0] rtc_evt_i,
	input  wire logic [`LPMC_USB_WKUPS-1:0] usb_wake_i,
	input  wire logic                  eth_wake_i,
	input  wire logic                  reset_pin_n_i,
	input  wire logic                  independent_watchdog_rst_i,
	input  wire logic                  wakeup_pin_i,
	output logic                       stop_wake_o,
	output logic                       standby_wake_o
);
	logic wakeup_pin_r;

	// Previous level kept so only a rising edge counts, not a held-high pin
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wakeup_pin_r <= 1'b1;
		end else if (ce_i) begin
			wakeup_pin_r <= wakeup_pin_i;
		end
	end

	assign stop_wake_o = (|ext_int_lines_i) | voltage_detector_output_i | (|rtc_evt_i)
		| (|usb_wake_i) | eth_wake_i;
	assign standby_wake_o = !reset_pin_n_i | independent_watchdog_rst_i
		| (wakeup_pin_i & !wakeup_pin_r) | (|rtc_evt_i);
endmodule // lpmc_wake_detect
`default_nettype wire
